// ---- src/ldcr_pkg.sv ----
// Constants for the LED driver control register bank
// What this block does
// - Rate bit picks 256 Hz or 558 Hz
// - Power save enable at config bit 5
// - Two-bit field selects controller clock source
// - Counter writes apply on slow clock tick
// - Counters are four bits, bits 3:0
// - Status read clears engine flag bits
// - Status bit 3 shows external clock use
// - Engine flags at status bits 2,1,0
// - Writing FFh to reset restores all registers
// - Fourth channel duty from its register when map field is 00
// - Fourth channel current at 0Fh, reset AFh
// - Channel map at 70h, reset 39h
// - Map field 00 direct, else engines 1-3
// - Engine mode 11b means direct control
package ldcr_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_CONFIG   = 8'h08;
    localparam logic [7:0] ADDR_ENG1_CNT = 8'h09;
    localparam logic [7:0] ADDR_ENG2_CNT = 8'h0A;
    localparam logic [7:0] ADDR_ENG3_CNT = 8'h0A;
    localparam logic [7:0] ADDR_STATUS   = 8'h0C;
    localparam logic [7:0] ADDR_SOFT_RST = 8'h0D;
    localparam logic [7:0] ADDR_W_DUTY   = 8'h0E;
    localparam logic [7:0] ADDR_W_CUR    = 8'h0F;
    localparam logic [7:0] ADDR_MAP      = 8'h70;

    // Reset values
    localparam logic [7:0] RST_CONFIG  = 8'h00;
    localparam logic [3:0] RST_COUNTER = 4'h0;
    localparam logic [7:0] RST_SOFT    = 8'h00;
    localparam logic [7:0] RST_W_DUTY  = 8'h00;
    localparam logic [7:0] RST_W_CUR   = 8'hAF;
    localparam logic [7:0] RST_MAP     = 8'h39;
    localparam logic [7:0] SOFT_RST_KEY = 8'hFF;

    // Field positions and masks
    localparam int         CFG_RATE_BIT  = 6;
    localparam int         CFG_PS_BIT    = 5;
    localparam logic [7:0] CFG_MASK      = 8'h63;
    localparam int         ST_EXT_BIT    = 3;
    localparam int         MAP_W_LSB     = 6;

    // Clock source field codes
    localparam logic [1:0] SRC_EXTERNAL = 2'h0;
    localparam logic [1:0] SRC_INT_A    = 2'h1;
    localparam logic [1:0] SRC_AUTO     = 2'h2;
    localparam logic [1:0] SRC_INT_B    = 2'h3;

    // Source map and engine mode codes
    localparam logic [1:0] MAP_DIRECT  = 2'h0;
    localparam logic [1:0] MODE_DIRECT = 2'h3;

    // Timing
    localparam int REF_CLK_HZ    = 40000000;
    localparam int PWM_SLOW_HZ   = 256;
    localparam int PWM_FAST_HZ   = 558;
    localparam int PWM_STEPS     = 256;
    localparam int SLOW_CLK_HZ   = 32768;
    localparam int PWM_SLOW_DIV  = REF_CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
    localparam int PWM_FAST_DIV  = REF_CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);
    localparam int SLOW_TICK_DIV = REF_CLK_HZ / SLOW_CLK_HZ;
    localparam int DIV_W         = 11;

endpackage

// ---- src/ldcr_pc_sync.sv ----
// One engine counter, applied on the slow clock tick
`timescale 1ns/10ps
module ldcr_pc_sync (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    // Host side
    input  wire logic       wr_in,
    input  wire logic [3:0] wdata_in,
    // Slow domain tick
    input  wire logic       tick_in,
    // Applied counter
    output logic      [3:0] value_out
);

    logic [3:0] pending_reg;
    logic       armed_reg;

    // Latest write waits here until the next slow tick
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pending_reg <= ldcr_pkg::RST_COUNTER;
            armed_reg   <= 1'b0;
        end else if (ce_in) begin
            if (wr_in) begin
                pending_reg <= wdata_in;
                armed_reg   <= 1'b1;
            end else if (tick_in) begin
                armed_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            value_out <= ldcr_pkg::RST_COUNTER;
        end else if (ce_in && tick_in && armed_reg && !wr_in) begin
            value_out <= pending_reg;
        end
    end

endmodule

// ---- src/ldcr_top.sv ----
// Control register bank of a four-channel LED driver
`timescale 1ns/10ps
module ldcr_top (
    // Clock, reset, enable
    input  wire logic       REF_CLK_IN,
    input  wire logic       RST_IN,
    input  wire logic       CLK_EN_IN,
    // Register port from the serial front end
    input  wire logic [7:0] REG_ADDR_IN,
    input  wire logic [7:0] REG_WDATA_IN,
    input  wire logic       REG_WR_IN,
    input  wire logic       REG_RD_IN,
    output logic      [7:0] REG_RDATA_OUT,
    output logic            REG_RVALID_OUT,
    // Clock sources
    input  wire logic       EXTERNAL_SLOW_CLOCK_INPUT_IN,
    input  wire logic       EXT_CLK_DETECTED_IN,
    // Engines
    input  wire logic [2:0] ENGINE_IRQ_IN,
    input  wire logic [5:0] EXECUTION_MODE_IN,
    input  wire logic [7:0] ENG1_DUTY_IN,
    input  wire logic [7:0] ENG2_DUTY_IN,
    input  wire logic [7:0] ENG3_DUTY_IN,
    // Counters to the engines
    output logic      [3:0] ENGINE_ONE_COUNTER_VALUE_OUT,
    output logic      [3:0] ENGINE_TWO_COUNTER_VALUE_OUT,
    output logic      [3:0] ENGINE_THREE_COUNTER_VALUE_OUT,
    // Fourth channel and controls
    output logic            W_PWM_OUT,
    output logic      [7:0] W_CURRENT_OUT,
    output logic            POWER_SAVE_ENABLE_OUT,
    output logic            EXTERNAL_CLOCK_IN_USE_OUT,
    output logic      [7:0] CHANNEL_MAP_OUT
);

    logic [7:0]  config_reg;
    logic [7:0]  soft_rst_reg;
    logic [7:0]  w_duty_reg;
    logic [7:0]  map_reg;
    logic [2:0]  flag_reg;
    logic        ext_used_reg;
    logic        slow_in_reg;
    logic        slow_tick_reg;
    logic [10:0] int_div_reg;
    logic [10:0] pwm_div_reg;
    logic [7:0]  pwm_phase_reg;
    logic [7:0]  duty_hold_reg;
    logic [7:0]  duty_next;
    logic [7:0]  rdata_next;
    logic        local_rst;
    logic        wr_cfg;
    logic        wr_map;
    logic [2:0]  cnt_wr;
    logic [3:0]  cnt_val [3];
    logic [7:0]  eng_duty [3];
    logic [10:0] pwm_limit;

    // Address decode, shared by the write and read paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    assign local_rst = RST_IN || (CLK_EN_IN && REG_WR_IN
                       && hit(REG_ADDR_IN, ldcr_pkg::ADDR_SOFT_RST)
                       && (REG_WDATA_IN == ldcr_pkg::SOFT_RST_KEY));

    assign wr_cfg = REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_CONFIG);
    assign wr_map = REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_MAP);
    // Both upper counters share one offset, so a write there lands in each
    assign cnt_wr[0] = REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_ENG1_CNT);
    assign cnt_wr[1] = REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_ENG2_CNT);
    assign cnt_wr[2] = REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_ENG3_CNT);

    assign eng_duty[0] = ENG1_DUTY_IN;
    assign eng_duty[1] = ENG2_DUTY_IN;
    assign eng_duty[2] = ENG3_DUTY_IN;

    // Configuration register
    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            config_reg <= ldcr_pkg::RST_CONFIG;
        end else if (CLK_EN_IN && wr_cfg) begin
            config_reg <= REG_WDATA_IN & ldcr_pkg::CFG_MASK;
        end
    end

    // Soft reset register keeps other values as plain storage
    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            soft_rst_reg <= ldcr_pkg::RST_SOFT;
        end else if (CLK_EN_IN && REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_SOFT_RST)) begin
            soft_rst_reg <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            w_duty_reg <= ldcr_pkg::RST_W_DUTY;
        end else if (CLK_EN_IN && REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_W_DUTY)) begin
            w_duty_reg <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            W_CURRENT_OUT <= ldcr_pkg::RST_W_CUR;
        end else if (CLK_EN_IN && REG_WR_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_W_CUR)) begin
            W_CURRENT_OUT <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            map_reg <= ldcr_pkg::RST_MAP;
        end else if (CLK_EN_IN && wr_map) begin
            map_reg <= REG_WDATA_IN;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            POWER_SAVE_ENABLE_OUT <= 1'b0;
            CHANNEL_MAP_OUT       <= ldcr_pkg::RST_MAP;
        end else if (CLK_EN_IN) begin
            POWER_SAVE_ENABLE_OUT <= config_reg[ldcr_pkg::CFG_PS_BIT];
            CHANNEL_MAP_OUT       <= map_reg;
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            ext_used_reg <= 1'b1;
        end else if (CLK_EN_IN) begin
            case (config_reg[1:0])
                ldcr_pkg::SRC_EXTERNAL: ext_used_reg <= 1'b1;
                ldcr_pkg::SRC_AUTO:     ext_used_reg <= EXT_CLK_DETECTED_IN;
                ldcr_pkg::SRC_INT_A:    ext_used_reg <= 1'b0;
                ldcr_pkg::SRC_INT_B:    ext_used_reg <= 1'b0;
                default:                ext_used_reg <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            EXTERNAL_CLOCK_IN_USE_OUT <= 1'b1;
        end else if (CLK_EN_IN) begin
            EXTERNAL_CLOCK_IN_USE_OUT <= ext_used_reg;
        end
    end

    // Slow tick from the external input edge or the internal divider
    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            slow_in_reg   <= 1'b0;
            int_div_reg   <= '0;
            slow_tick_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            slow_in_reg <= EXTERNAL_SLOW_CLOCK_INPUT_IN;
            if (int_div_reg == 11'(ldcr_pkg::SLOW_TICK_DIV - 1)) begin
                int_div_reg <= '0;
            end else begin
                int_div_reg <= int_div_reg + 11'h001;
            end
            if (ext_used_reg) begin
                slow_tick_reg <= EXTERNAL_SLOW_CLOCK_INPUT_IN && !slow_in_reg;
            end else begin
                slow_tick_reg <= (int_div_reg == 11'(ldcr_pkg::SLOW_TICK_DIV - 1));
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_cnt
            ldcr_pc_sync u_sync (
                .clk_in    (REF_CLK_IN),
                .rst_in    (local_rst),
                .ce_in     (CLK_EN_IN),
                .wr_in     (cnt_wr[gi]),
                .wdata_in  (REG_WDATA_IN[3:0]),
                .tick_in   (slow_tick_reg),
                .value_out (cnt_val[gi])
            );
        end
    endgenerate

    assign ENGINE_ONE_COUNTER_VALUE_OUT   = cnt_val[0];
    assign ENGINE_TWO_COUNTER_VALUE_OUT   = cnt_val[1];
    assign ENGINE_THREE_COUNTER_VALUE_OUT = cnt_val[2];

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            flag_reg <= 3'h0;
        end else if (CLK_EN_IN) begin
            if (REG_RD_IN && hit(REG_ADDR_IN, ldcr_pkg::ADDR_STATUS)) begin
                flag_reg <= ENGINE_IRQ_IN;
            end else begin
                flag_reg <= flag_reg | ENGINE_IRQ_IN;
            end
        end
    end

    // Readback mux
    always_comb begin
        rdata_next = 8'h00;
        case (REG_ADDR_IN)
            ldcr_pkg::ADDR_CONFIG:   rdata_next = config_reg;
            ldcr_pkg::ADDR_ENG1_CNT: rdata_next = {4'h0, cnt_val[0]};
            // Shared offset reads back the second engine
            ldcr_pkg::ADDR_ENG2_CNT: rdata_next = {4'h0, cnt_val[1]};
            ldcr_pkg::ADDR_STATUS:   rdata_next = {4'h0, ext_used_reg, flag_reg};
            ldcr_pkg::ADDR_SOFT_RST: rdata_next = soft_rst_reg;
            ldcr_pkg::ADDR_W_DUTY:   rdata_next = w_duty_reg;
            ldcr_pkg::ADDR_W_CUR:    rdata_next = W_CURRENT_OUT;
            ldcr_pkg::ADDR_MAP:      rdata_next = map_reg;
            default:                 rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            REG_RDATA_OUT  <= 8'h00;
            REG_RVALID_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            REG_RVALID_OUT <= REG_RD_IN;
            if (REG_RD_IN) begin
                REG_RDATA_OUT <= rdata_next;
            end
        end
    end

    always_comb begin
        duty_next = w_duty_reg;
        case (map_reg[ldcr_pkg::MAP_W_LSB +: 2])
            ldcr_pkg::MAP_DIRECT: duty_next = w_duty_reg;
            2'h1: duty_next = (EXECUTION_MODE_IN[5:4] == ldcr_pkg::MODE_DIRECT) ? w_duty_reg : eng_duty[0];
            2'h2: duty_next = (EXECUTION_MODE_IN[3:2] == ldcr_pkg::MODE_DIRECT) ? w_duty_reg : eng_duty[1];
            2'h3: duty_next = (EXECUTION_MODE_IN[1:0] == ldcr_pkg::MODE_DIRECT) ? w_duty_reg : eng_duty[2];
            default: duty_next = w_duty_reg;
        endcase
    end

    assign pwm_limit = config_reg[ldcr_pkg::CFG_RATE_BIT] ? 11'(ldcr_pkg::PWM_FAST_DIV - 1)
                                                          : 11'(ldcr_pkg::PWM_SLOW_DIV - 1);

    // Duty is sampled once per period so a change never splits a pulse
    always_ff @(posedge REF_CLK_IN) begin
        if (local_rst) begin
            pwm_div_reg   <= '0;
            pwm_phase_reg <= 8'h00;
            duty_hold_reg <= 8'h00;
            W_PWM_OUT     <= 1'b0;
        end else if (CLK_EN_IN) begin
            if (pwm_div_reg >= pwm_limit) begin
                pwm_div_reg   <= '0;
                pwm_phase_reg <= pwm_phase_reg + 8'h01;
                if (pwm_phase_reg == 8'hFF) begin
                    duty_hold_reg <= duty_next;
                end
            end else begin
                pwm_div_reg <= pwm_div_reg + 11'h001;
            end
            W_PWM_OUT <= (pwm_phase_reg < duty_hold_reg);
        end
    end

endmodule

// ---- verification/ldcr_checker.sv ----
// Port assertions for the LED driver control register bank
`timescale 1ns/10ps
module ldcr_checker (
    // Clock and register port
    input wire logic       REF_CLK_IN,
    input wire logic       RST_IN,
    input wire logic       CLK_EN_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic       REG_WR_IN,
    input wire logic       REG_RD_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    // Engines and outputs
    input wire logic [2:0] ENGINE_IRQ_IN,
    input wire logic [3:0] ENGINE_ONE_COUNTER_VALUE_OUT,
    input wire logic [7:0] W_CURRENT_OUT,
    input wire logic       POWER_SAVE_ENABLE_OUT,
    input wire logic       EXTERNAL_CLOCK_IN_USE_OUT,
    input wire logic [7:0] CHANNEL_MAP_OUT
);
    wire logic wr = REG_WR_IN && CLK_EN_IN;
    wire logic st = REG_RD_IN && CLK_EN_IN && REG_ADDR_IN == 8'h0C;
    default clocking @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_ps; wr && REG_ADDR_IN == 8'h08 |-> ##2 POWER_SAVE_ENABLE_OUT == $past(REG_WDATA_IN[5], 2); endproperty
    a_ps: assert property (p_ps) else $error("power save output wrong");
    property p_int; wr && REG_ADDR_IN == 8'h08 && REG_WDATA_IN[0] |-> ##3 !EXTERNAL_CLOCK_IN_USE_OUT; endproperty
    a_int: assert property (p_int) else $error("internal clock not in use");
    property p_ext; wr && REG_ADDR_IN == 8'h08 && REG_WDATA_IN[1:0] == 2'h0 |-> ##3 EXTERNAL_CLOCK_IN_USE_OUT; endproperty
    a_ext: assert property (p_ext) else $error("external clock not in use");
    property p_set;
        (CLK_EN_IN && ENGINE_IRQ_IN != 3'h0) ##1 st |=>
            (REG_RDATA_OUT[2:0] & $past(ENGINE_IRQ_IN, 2)) == $past(ENGINE_IRQ_IN, 2);
    endproperty
    a_set: assert property (p_set) else $error("engine flag missing");
    property p_clr; (st && ENGINE_IRQ_IN == 3'h0) ##1 (st && ENGINE_IRQ_IN == 3'h0) |=> REG_RDATA_OUT[2:0] == 3'h0; endproperty
    a_clr: assert property (p_clr) else $error("flags not cleared by read");
    property p_cnt; wr && REG_ADDR_IN == 8'h09 |=> $stable(ENGINE_ONE_COUNTER_VALUE_OUT); endproperty
    a_cnt: assert property (p_cnt) else $error("counter applied before slow tick");
    property p_cur; wr && REG_ADDR_IN == 8'h0F |=> W_CURRENT_OUT == $past(REG_WDATA_IN); endproperty
    a_cur: assert property (p_cur) else $error("current setting not stored");
    property p_soft; wr && REG_ADDR_IN == 8'h0D && REG_WDATA_IN == 8'hFF |=> W_CURRENT_OUT == 8'hAF ##1 CHANNEL_MAP_OUT == 8'h39; endproperty
    a_soft: assert property (p_soft) else $error("soft reset incomplete");
endmodule

bind ldcr_top ldcr_checker ldcr_checker_i (.REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .CLK_EN_IN(CLK_EN_IN),
    .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .ENGINE_IRQ_IN(ENGINE_IRQ_IN),
    .ENGINE_ONE_COUNTER_VALUE_OUT(ENGINE_ONE_COUNTER_VALUE_OUT), .W_CURRENT_OUT(W_CURRENT_OUT),
    .POWER_SAVE_ENABLE_OUT(POWER_SAVE_ENABLE_OUT), .EXTERNAL_CLOCK_IN_USE_OUT(EXTERNAL_CLOCK_IN_USE_OUT),
    .CHANNEL_MAP_OUT(CHANNEL_MAP_OUT));

// ---- verification/ldcr_host_model.sv ----
// Host model driving the register port
`timescale 1ns/10ps
module ldcr_host_model (
    // Clock
    input  wire logic       clk_in,
    // Register port
    output logic      [7:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    int cyc = 0;
    int last_pc = -7000;
    initial begin
        addr_out = 8'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end
    always @(posedge clk_in) cyc <= cyc + 1;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h09 || a == 8'h0A) begin
            while (cyc - last_pc < 6200) @(negedge clk_in);
            last_pc = cyc;
        end
        @(negedge clk_in);
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
        // Released data must not look valid
        wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, input int n, output logic [7:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out = 1'b1;
        repeat (n) @(negedge clk_in);
        rd_out = 1'b0;
        d = rvalid_in ? rdata_in : 8'hXX;
    endtask
endmodule

// ---- verification/led_driver_control_registers_tb.sv ----
// Self-checking bench for the LED driver control register bank
`timescale 1ns/10ps
module led_driver_control_registers_tb;
    logic       clk;
    logic       sclk;
    logic       rst;
    logic       det;
    logic [2:0] irq;
    logic [5:0] mode;
    logic [7:0] addr, wdata, rdata, cur, map;
    logic       wr_s, rd_s, rvalid, pwm, ps, ext;
    logic [3:0] c1, c2, c3;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         rel = 0;

    ldcr_top ldcr_top_i (.REF_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(1'b1), .REG_ADDR_IN(addr),
        .REG_WDATA_IN(wdata), .REG_WR_IN(wr_s), .REG_RD_IN(rd_s), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
        .EXTERNAL_SLOW_CLOCK_INPUT_IN(sclk), .EXT_CLK_DETECTED_IN(det), .ENGINE_IRQ_IN(irq),
        .EXECUTION_MODE_IN(mode), .ENG1_DUTY_IN(8'h00), .ENG2_DUTY_IN(8'h00), .ENG3_DUTY_IN(8'h00),
        .ENGINE_ONE_COUNTER_VALUE_OUT(c1), .ENGINE_TWO_COUNTER_VALUE_OUT(c2),
        .ENGINE_THREE_COUNTER_VALUE_OUT(c3), .W_PWM_OUT(pwm), .W_CURRENT_OUT(cur),
        .POWER_SAVE_ENABLE_OUT(ps), .EXTERNAL_CLOCK_IN_USE_OUT(ext), .CHANNEL_MAP_OUT(map));
    ldcr_host_model ldcr_host_model_i (.clk_in(clk), .addr_out(addr), .wdata_out(wdata), .wr_out(wr_s),
        .rd_out(rd_s), .rdata_in(rdata), .rvalid_in(rvalid));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Slow clock of 610 reference cycles per half period; it toggles on a falling edge
    initial begin
        sclk = 1'b0;
        forever #15250 sclk = ~sclk;
    end
    // Ceiling well beyond one fast PWM period plus the setup
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        ldcr_host_model_i.wr(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        ldcr_host_model_i.rd(a, 1, d);
        chk(d, e);
    endtask

    task automatic t_reset;
        rchk(8'h08, 8'h00);
        rchk(8'h09, 8'h00);
        rchk(8'h0C, 8'h08);
        rchk(8'h0D, 8'h00);
        rchk(8'h0E, 8'h00);
        rchk(8'h0F, 8'hAF);
        rchk(8'h70, 8'h39);
        chk(cur, 8'hAF);
        chk(map, 8'h39);
    endtask
    // Engine one in direct mode, white channel mapped to it, full duty
    task automatic t_pwm_start;
        mode = 6'h30;
        wr(8'h0E, 8'hFF);
        wr(8'h70, 8'h79);
        rchk(8'h70, 8'h79);
    endtask
    task automatic t_config;
        logic [1:0] k;
        logic       e;
        wr(8'h08, 8'hFF);
        rchk(8'h08, 8'h63);
        chk({7'h00, ps}, 8'h01);
        det = 1'b1;
        for (int c = 0; c < 5; c++) begin
            k = (c == 4) ? 2'h2 : 2'(c);
            det = (c != 4);
            e = (k == 2'h0) || (k == 2'h2 && det);
            wr(8'h08, 8'h40 | {6'h00, k});
            @(negedge clk);
            rchk(8'h0C, {4'h0, e, 3'h0});
            chk({7'h00, ext}, {7'h00, e});
        end
        chk({7'h00, ps}, 8'h00);
    endtask
    task automatic t_status;
        logic [7:0] d;
        for (int i = 0; i < 2; i++) begin
            irq = i ? 3'h2 : 3'h5;
            ldcr_host_model_i.rd(8'h0C, 1, d);
            irq = 3'h0;
            chk(d & 8'h07, {5'h00, i ? 3'h2 : 3'h5});
            rchk(8'h0C, {5'h00, i ? 3'h2 : 3'h5});
            ldcr_host_model_i.rd(8'h0C, 2, d);
            chk(d & 8'h07, 8'h00);
        end
    endtask
    task automatic t_counter;
        wr(8'h08, 8'h41);
        wr(8'h09, 8'hFA);
        rchk(8'h09, 8'h00);
        repeat (1300) @(negedge clk);
        chk({4'h0, c1}, 8'h0A);
        rchk(8'h09, 8'h0A);
        wr(8'h0A, 8'h05);
        repeat (1300) @(negedge clk);
        chk({c2, c3}, 8'h55);
        rchk(8'h0A, 8'h05);
        // External source keeps the fast rate; counter now moves on the slow pin edge
        wr(8'h08, 8'h40);
        wr(8'h09, 8'h03);
        repeat (1300) @(negedge clk);
        chk({4'h0, c1}, 8'h03);
        chk({7'h00, ext}, 8'h01);
    endtask
    task automatic t_misc;
        wr(8'h0F, 8'hB4);
        chk(cur, 8'hB4);
        wr(8'h0B, 8'h55);
        rchk(8'h0B, 8'h00);
    endtask
    // First period runs on duty zero; full duty shows after one fast period
    task automatic t_pwm_check;
        int n;
        n = 0;
        while (pwm !== 1'b1 && n < 80000) begin
            @(negedge clk);
            n++;
        end
        n = cyc - rel;
        chk({7'h00, n > 256 * 280 - 700 && n < 256 * 280 + 700}, 8'h01);
    endtask
    task automatic t_soft;
        wr(8'h0D, 8'h5A);
        rchk(8'h0D, 8'h5A);
        wr(8'h0D, 8'hFF);
        rchk(8'h0F, 8'hAF);
        rchk(8'h70, 8'h39);
        rchk(8'h0D, 8'h00);
        rchk(8'h0E, 8'h00);
    endtask

    initial begin
        rst = 1'b1;
        det = 1'b0;
        irq = 3'h0;
        mode = 6'h00;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        rel = cyc;
        t_reset();
        t_pwm_start();
        t_config();
        t_status();
        t_counter();
        t_misc();
        t_pwm_check();
        t_soft();
        finish_test();
    end
endmodule
